// ---- pwb_pkg.sv ----
// Constants and state types for the parallel word bitslip block.
package pwb_pkg;

	// Clock cycles per word clock tick in SDR and DDR capture
	localparam int SDR_DIVIDE      = 8;
	localparam int DDR_DIVIDE      = 4;
	// Reference capture counts: normal word and slipped word
	localparam int CAPTURE_BITS    = 8;
	localparam int SLIP_BITS       = 9;
	// Slips in one full wrap before status pulse
	localparam int WRAP_SLIPS      = 8;
	// Startup cycles of the permutation path
	localparam int PERM_LATENCY    = 2;
	// Reset values
	localparam logic [2:0] OFFSET_RESET = 3'h0;
	localparam logic [2:0] SLIPCNT_RESET = 3'h0;
	localparam logic [1:0] FILL_RESET   = 2'h0;

	// Permutation path startup states
	typedef enum logic [2:0] {
		PWB_IDLE  = 3'b001,
		PWB_HIST  = 3'b010,
		PWB_VALID = 3'b100
	} pwb_state_type;

endpackage

// ---- pwb_bitslip.sv ----
// Parallel word bitslip: rotation path, permutation path and serial reference model.
`timescale 1ns/1ns
module pwb_bitslip #(
	parameter int word_width_param   = 8,
	parameter int extra_input_stage  = 0,
	parameter int ddr_mode           = 0
) (
	input  wire logic                                       mclk_i,
	input  wire logic                                       sys_rst_i,
	input  wire logic [word_width_param-1:0]                data_i,
	input  wire logic                                       slip_i,
	input  wire logic                                       serial_bit_i,
	output logic      [word_width_param-1:0]                data_o,
	output logic                                            slip_status_out_o,
	output logic      [word_width_param*word_width_param-1:0] perm_o,
	output logic                                            perm_valid_o,
	output logic      [word_width_param-1:0]                ser_word_o,
	output logic                                            parallel_word_clock_o
);
	// Overview of the three paths held in this module.
	//
	// Rotation path:
	//   Two cascaded word registers hold the current and the previous word.
	//   A multiplexer takes a word-wide window out of their concatenation.
	//   The window start is the accumulated slip offset.
	//   With offset zero the older word passes unchanged, so the path is a plain pipeline.
	//   Each slip request moves the window start up by one bit.
	//   The offset wraps from the top value back to zero.
	//   The new alignment holds for every later word until another slip arrives.
	//   Slip requests are edge detected, so a long request still counts once.
	//   A slip counter pulses the status output once per eight slips.
	//
	// Permutation path:
	//   A history register keeps the last word.
	//   Every rotation of the word pair is registered at once, one slice per offset.
	//   The output is marked valid from the second edge after reset onward.
	//   Downstream logic picks whichever slice carries the wanted alignment.
	//
	// Serial reference model:
	//   Serial bits enter a shift register one per clock, newest at the top.
	//   A capture pulse copies the shift register to a holding register.
	//   Normally the capture comes every word width bits.
	//   After a slip request it comes one bit later, dropping the oldest bit.
	//   A divided tick moves the holding register to the reference output.
	//
	// Latency:
	//   Without the extra input stage, data at edge n shows on data_o after edge n+2.
	//   With the extra input stage, one more edge is added.
	//   The permutation path shares the same optional input stage.
	//
	// Limitations:
	//   The status counter wraps modulo eight whatever the word width.
	//   The reference model shifts one bit per clock in both capture modes;
	//   the capture mode only changes the tick ratio.
	//   Slip requests need the request line low for at least one edge between them.
	localparam int W    = word_width_param;
	localparam int OW   = $clog2(W);
	localparam int DIV  = (ddr_mode != 0) ? (W / 2) : W;
	localparam int DW   = $clog2(DIV) + 1;
	localparam int CW   = 4;

	// Input stage
	logic [W-1:0] in_stage;
	logic [W-1:0] word_in;

	// Rotation path state
	logic [W-1:0]    cur_word;
	logic [W-1:0]    prev_word;
	logic [OW-1:0]   offset;
	logic [2:0]      slip_cnt;
	logic            slip_d;
	logic [W-1:0]    next_cur_word;
	logic [W-1:0]    next_prev_word;
	logic [OW-1:0]   next_offset;
	logic [2:0]      next_slip_cnt;
	logic            next_slip_d;
	logic [W-1:0]    next_data;
	logic            next_status;
	logic [2*W-1:0]  pair;
	logic            slip_pulse;

	// Permutation path state
	pwb_pkg::pwb_state_type state;
	pwb_pkg::pwb_state_type next_state;
	logic [W-1:0]           hist_word;
	logic [W-1:0]           next_hist_word;
	logic [W*W-1:0]         next_perm;
	logic                   next_perm_valid;
	logic [2*W-1:0]         perm_win;

	// Serial reference model state
	logic [W-1:0]   shift_reg;
	logic [W-1:0]   hold_reg;
	logic [CW-1:0]  bit_cnt;
	logic           slip_pend;
	logic [DW-1:0]  div_cnt;
	logic [W-1:0]   next_shift_reg;
	logic [W-1:0]   next_hold_reg;
	logic [CW-1:0]  next_bit_cnt;
	logic           next_slip_pend;
	logic [DW-1:0]  next_div_cnt;
	logic [W-1:0]   next_ser_word;
	logic           next_word_clock;
	logic           ser_slip_d;
	logic           next_ser_slip_d;

	// Optional extra input register, one cycle of latency.
	// The register trades one edge of latency for a shorter input timing path.
	// When the stage is left out the register is held at zero and unread.
	generate
		if (extra_input_stage != 0) begin : g_in_reg
			always_ff @(posedge mclk_i) begin
				if (sys_rst_i) begin
					in_stage <= '0;
				end else begin
					in_stage <= data_i;
				end
			end
			assign word_in = in_stage;
		end else begin : g_in_wire
			always_ff @(posedge mclk_i) begin
				in_stage <= '0;
			end
			assign word_in = data_i;
		end
	endgenerate

	// Slip request edge and pair of cascaded words.
	// Only a rising edge counts, so a request held for many edges slips once.
	// The pair puts the newer word in the upper half, the older in the lower half.
	assign slip_pulse = slip_i && !slip_d;
	assign pair       = {cur_word, prev_word};

	// Rotation path next values.
	// The new offset is used by data_o one edge after the slip edge.
	// The status pulse lasts exactly one cycle per eighth slip.
	always_comb begin
		next_prev_word = cur_word;
		next_cur_word  = word_in;
		next_slip_d    = slip_i;
		next_offset    = offset;
		next_slip_cnt  = slip_cnt;
		next_status    = 1'b0;
		if (slip_pulse) begin
			if (offset == OW'(W - 1)) begin
				next_offset = '0;
			end else begin
				next_offset = offset + OW'(1);
			end
			next_slip_cnt = slip_cnt + 3'h1;
			if (slip_cnt == 3'(pwb_pkg::WRAP_SLIPS - 1)) begin
				next_status = 1'b1;
			end
		end
		// Offset zero selects the older word unchanged
		next_data = pair[offset +: W];
	end

	// Rotation path registers.
	// Reset empties the pipeline and clears the offset and slip count.
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			cur_word          <= '0;
			prev_word         <= '0;
			offset            <= OW'(pwb_pkg::OFFSET_RESET);
			slip_cnt          <= pwb_pkg::SLIPCNT_RESET;
			slip_d            <= 1'b0;
			data_o            <= '0;
			slip_status_out_o <= 1'b0;
		end else begin
			cur_word          <= next_cur_word;
			prev_word         <= next_prev_word;
			offset            <= next_offset;
			slip_cnt          <= next_slip_cnt;
			slip_d            <= next_slip_d;
			data_o            <= next_data;
			slip_status_out_o <= next_status;
		end
	end

	// Permutation path next values.
	// The start sequence is idle, then history loaded, then permutations valid.
	// The window is the current word above the history word.
	// Slice k of the output holds the window shifted down by k bits.
	always_comb begin
		perm_win        = {word_in, hist_word};
		next_state      = state;
		next_hist_word  = word_in;
		next_perm_valid = 1'b0;
		next_perm       = perm_o;
		case (state)
			pwb_pkg::PWB_IDLE: begin
				next_state = pwb_pkg::PWB_HIST;
			end
			pwb_pkg::PWB_HIST: begin
				next_state = pwb_pkg::PWB_VALID;
			end
			pwb_pkg::PWB_VALID: begin
				next_state = pwb_pkg::PWB_VALID;
			end
			default: begin
				next_state = pwb_pkg::PWB_IDLE;
			end
		endcase
		if (state != pwb_pkg::PWB_IDLE) begin
			for (int k = 0; k < W; k++) begin
				next_perm[k*W +: W] = perm_win[k +: W];
			end
		end
		if (state == pwb_pkg::PWB_HIST || state == pwb_pkg::PWB_VALID) begin
			next_perm_valid = 1'b1;
		end
	end

	// Permutation path registers.
	// Valid stays high every cycle once the start sequence is done.
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			state        <= pwb_pkg::PWB_IDLE;
			hist_word    <= '0;
			perm_o       <= '0;
			perm_valid_o <= 1'b0;
		end else begin
			state        <= next_state;
			hist_word    <= next_hist_word;
			perm_o       <= next_perm;
			perm_valid_o <= next_perm_valid;
		end
	end

	// Serial reference model next values.
	// Shifting never pauses, so no bit is lost at a capture.
	// A slip edge landing on a capture edge arms the next slip; the set wins.
	// The tick loads the word captured before it, one word behind the capture.
	always_comb begin
		next_ser_slip_d = slip_i;
		next_shift_reg  = {serial_bit_i, shift_reg[W-1:1]};
		next_hold_reg   = hold_reg;
		next_bit_cnt    = bit_cnt + CW'(1);
		next_slip_pend  = slip_pend;
		next_ser_word   = ser_word_o;
		next_word_clock = 1'b0;
		next_div_cnt    = div_cnt + DW'(1);
		if (slip_i && !ser_slip_d) begin
			next_slip_pend = 1'b1;
		end
		// Capture after a full word, or one bit later when slipping
		if ((!slip_pend && bit_cnt == CW'(W - 1)) || (slip_pend && bit_cnt == CW'(W))) begin
			next_hold_reg  = next_shift_reg;
			next_bit_cnt   = '0;
			next_slip_pend = slip_i && !ser_slip_d;
		end
		// Divided word clock tick
		if (div_cnt == DW'(DIV - 1)) begin
			next_div_cnt    = '0;
			next_word_clock = 1'b1;
			next_ser_word   = hold_reg;
		end
	end

	// Serial reference model registers.
	// Reset aligns the bit counter and the tick divider to the same start.
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			shift_reg             <= '0;
			hold_reg              <= '0;
			bit_cnt               <= '0;
			slip_pend             <= 1'b0;
			ser_slip_d            <= 1'b0;
			div_cnt               <= '0;
			ser_word_o            <= '0;
			parallel_word_clock_o <= 1'b0;
		end else begin
			shift_reg             <= next_shift_reg;
			hold_reg              <= next_hold_reg;
			bit_cnt               <= next_bit_cnt;
			slip_pend             <= next_slip_pend;
			ser_slip_d            <= next_ser_slip_d;
			div_cnt               <= next_div_cnt;
			ser_word_o            <= next_ser_word;
			parallel_word_clock_o <= next_word_clock;
		end
	end

endmodule

// ---- pwb_bitslip_sva.sv ----
// Concurrent checks on the bitslip block ports.
`timescale 1ns/1ns
module pwb_bitslip_sva #(
	parameter int word_width_param = 8,
	parameter int ddr_mode         = 0
) (
	input wire logic                                         mclk_i,
	input wire logic                                         sys_rst_i,
	input wire logic [word_width_param-1:0]                  data_i,
	input wire logic                                         slip_i,
	input wire logic                                         serial_bit_i,
	input wire logic [word_width_param-1:0]                  data_o,
	input wire logic                                         slip_status_out_o,
	input wire logic [word_width_param*word_width_param-1:0] perm_o,
	input wire logic                                         perm_valid_o,
	input wire logic [word_width_param-1:0]                  ser_word_o,
	input wire logic                                         parallel_word_clock_o
);
	localparam int TICK_DIV = (ddr_mode != 0) ? word_width_param / 2 : word_width_param;
	logic [3:0] gap;
	logic       seen;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	// Cycles since the last word tick
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			gap  <= 4'h0;
			seen <= 1'b0;
		end else if (parallel_word_clock_o) begin
			gap  <= 4'h0;
			seen <= 1'b1;
		end else begin
			gap  <= gap + 4'h1;
		end
	end
	// First edge after reset, and a spell of steady input with no new slip
	sequence released;
		$past(sys_rst_i) && !sys_rst_i;
	endsequence
	sequence calm_in;
		(!$rose(slip_i) && $stable(data_i))[*5];
	endsequence
	chk_reset_zero: assert property (released |-> data_o == '0 && !slip_status_out_o)
		else $error("outputs not cleared by reset");
	chk_perm_start: assert property (released |-> ##[1:2] perm_valid_o)
		else $error("permutations not valid after startup");
	chk_perm_steady: assert property (perm_valid_o |=> perm_valid_o)
		else $error("permutation valid dropped");
	chk_perm_rot: assert property ((perm_valid_o && $stable(data_i))[*3] |->
		perm_o[2*word_width_param-1:word_width_param] ==
		{data_i[0], data_i[word_width_param-1:1]})
		else $error("one-bit rotation slice wrong");
	chk_arrange_kept: assert property (calm_in |=> $stable(data_o))
		else $error("arrangement changed without a slip");
	chk_status_pulse: assert property (slip_status_out_o |=> !slip_status_out_o)
		else $error("status longer than one cycle");
	chk_status_cause: assert property (slip_status_out_o |-> $past(slip_i) || $past(slip_i, 2))
		else $error("status without a slip");
	chk_tick_rate: assert property (parallel_word_clock_o |-> ##TICK_DIV parallel_word_clock_o)
		else $error("word tick missing after one divide period");
	chk_tick_gap: assert property (parallel_word_clock_o && seen |-> gap == 4'(TICK_DIV - 1))
		else $error("word tick spacing wrong");
endmodule
bind pwb_bitslip pwb_bitslip_sva #(.word_width_param(word_width_param), .ddr_mode(ddr_mode)) u_chk (
	.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .data_i(data_i), .slip_i(slip_i),
	.serial_bit_i(serial_bit_i), .data_o(data_o), .slip_status_out_o(slip_status_out_o),
	.perm_o(perm_o), .perm_valid_o(perm_valid_o), .ser_word_o(ser_word_o),
	.parallel_word_clock_o(parallel_word_clock_o));

// ---- pwb_source.sv ----
// Deserializer stand-in: parallel word stream and repeating serial pattern.
`timescale 1ns/1ns
module pwb_source (
	input  wire logic       mclk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       step_i,
	output logic      [7:0] word_o = 8'hB4,
	output logic            serial_bit_o
);
	logic [2:0] bit_idx = 3'h0;
	logic [7:0] pattern = 8'hB1;
	// Words advance on request; serial bits follow each other with no gap
	always @(posedge mclk_i) begin
		if (sys_rst_i) begin
			word_o <= 8'hB4;
			bit_idx <= 3'h0;
		end else begin
			if (step_i)
				word_o <= word_o + 8'h13;
			bit_idx <= bit_idx + 3'h1;
		end
	end
	assign serial_bit_o = pattern[bit_idx];
endmodule

// ---- test_parallel_word_bitslip.sv ----
// Self-checking bench for the bitslip block.
`timescale 1ns/1ns
module test_parallel_word_bitslip;
	logic        mclk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        slip_i = 1'b0;
	logic        step = 1'b0;
	logic [7:0]  data_i, data_o, ser_word_o, d1, d2, d3, d4, v, w;
	logic [63:0] perm_o;
	logic [3:0]  data_o4;
	logic        serial_bit_i, slip_status_out_o, perm_valid_o, parallel_word_clock_o;
	int          n_fail = 0, checks = 0, n_stat = 0;
	always #20 mclk_i = ~mclk_i;
	pwb_source src (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .step_i(step),
		.word_o(data_i), .serial_bit_o(serial_bit_i));
	pwb_bitslip #(.word_width_param(8), .extra_input_stage(0), .ddr_mode(0)) dut (
		.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .data_i(data_i), .slip_i(slip_i),
		.serial_bit_i(serial_bit_i), .data_o(data_o), .slip_status_out_o(slip_status_out_o),
		.perm_o(perm_o), .perm_valid_o(perm_valid_o), .ser_word_o(ser_word_o),
		.parallel_word_clock_o(parallel_word_clock_o));
	// Narrow build with extra input stage and double data rate tick
	pwb_bitslip #(.word_width_param(4), .extra_input_stage(1), .ddr_mode(1)) dut4 (
		.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .data_i(data_i[3:0]), .slip_i(slip_i),
		.serial_bit_i(serial_bit_i), .data_o(data_o4), .slip_status_out_o(),
		.perm_o(), .perm_valid_o(), .ser_word_o(), .parallel_word_clock_o());
	// Input history and status pulse count
	always @(posedge mclk_i) begin
		d1 <= data_i;
		d2 <= d1;
		d3 <= d2;
		d4 <= d3;
		if (slip_status_out_o === 1'b1)
			n_stat <= n_stat + 1;
	end
	function automatic logic [7:0] rotr(input logic [7:0] x, input int k);
		logic [15:0] t;
		t = {x, x} >> k;
		return t[7:0];
	endfunction
	function automatic logic [3:0] rot4(input logic [3:0] x, input int k);
		logic [7:0] t;
		t = {x, x} >> (k % 4);
		return t[3:0];
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic slip();
		@(posedge mclk_i);
		slip_i <= 1'b1;
		repeat (4) @(posedge mclk_i); // Held half a word period
		slip_i <= 1'b0;
		tick(24);
	endtask
	// Unslipped words come out two edges later, three on the narrow build with the extra input stage
	task automatic t_pipe();
		@(posedge mclk_i);
		step <= 1'b1;
		tick(3);
		repeat (8) begin
			check(data_o, d3);
			check({4'h0, data_o4}, {4'h0, d4[3:0]});
			tick(1);
		end
		@(posedge mclk_i);
		step <= 1'b0;
		tick(4);
		$display("pipeline test done");
	endtask
	// Eight long slips: accumulate, wrap, one status pulse
	task automatic t_slip();
		int k;
		int s0;
		v = data_i;
		w = ser_word_o;
		s0 = n_stat;
		for (k = 1; k <= 8; k++) begin
			slip();
			check(data_o, rotr(v, k));
			check({4'h0, data_o4}, {4'h0, rot4(v[3:0], k)});
			w = rotr(w, 1);
			check(ser_word_o, w);
		end
		check(8'(n_stat - s0), 8'h01);
		$display("slip test done");
	endtask
	// Mid-run reset clears the offset; permutations all present
	task automatic t_reset();
		int k;
		slip();
		slip();
		@(posedge mclk_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		tick(6);
		v = data_i;
		check(data_o, v);
		check({7'h00, perm_valid_o}, 8'h01);
		for (k = 0; k < 8; k++)
			check(perm_o[k*8 +: 8], rotr(v, k));
		$display("reset test done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Watchdog well beyond the expected run
	initial begin
		#80000;
		n_fail++;
		tally_and_finish();
	end
	initial begin
		repeat (4) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		t_pipe();
		t_slip();
		t_reset();
		tally_and_finish();
	end
endmodule
